// file: verilog/fault_history_log_defines.svh
// constants of the fault history log: parameter addresses, fields, counts
`ifndef FAULT_HISTORY_LOG_DEFINES_SVH
`define FAULT_HISTORY_LOG_DEFINES_SVH

// ----------------------------------------------------------------
// parameter addresses
// ----------------------------------------------------------------
`define ADDR_ERASE_HISTORY     16'h3b08
`define ADDR_READ_PTR_RESET    16'h3b0a
`define ADDR_ENTRY_NUMBER      16'h3c02
`define ADDR_ENTRY_CLASS       16'h3c04
`define ADDR_ENTRY_TIME        16'h3c06
`define ADDR_ENTRY_EXTRA_INFO  16'h3c08

// ----------------------------------------------------------------
// command values and history shape
// ----------------------------------------------------------------
`define CMD_EXECUTE            16'h0001
`define HIST_DEPTH             10
`define ERASE_CYCLES           10

// ----------------------------------------------------------------
// status word layout
// ----------------------------------------------------------------
`define STATUS_ERR_BIT         13
`define STATUS_STATE_LSB       0
`define STATUS_STATE_W         4
`define STATE_QUICK_STOP       4'h7
`define STATE_FAULT_REACTION   4'h8
`define STATE_FAULT            4'h9

// ----------------------------------------------------------------
// error classes and value limits
// ----------------------------------------------------------------
`define CLASS_WARNING          3'h0
`define CLASS_QSTOP_7          3'h1
`define CLASS_QSTOP_8_9        3'h2
`define CLASS_FATAL            3'h3
`define CLASS_FATAL_LOCKED     3'h4
`define TIME_MAX               32'h1fffffff

`endif

// file: verilog/fault_history_pkg.sv
// types shared by the fault history log
package fault_history_pkg;

	typedef struct packed {
		logic [15:0] number;
		logic [2:0]  cls;
		logic [31:0] time_s;
		logic [15:0] info;
	} entry_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] number;
		logic [2:0]  cls;
		logic [15:0] info;
	} fault_event_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wrData;
	} param_req_type;

	typedef enum logic [0:0] {
		ERASE_IDLE = 1'b0,
		ERASE_BUSY = 1'b1
	} erase_state_type;

endpackage

// file: verilog/history_slot.sv
// one slot of the fault history memory
module history_slot #(
	parameter int W = 67
) (
	input  wire logic         clk,
	input  wire logic         clear,
	input  wire logic         load,
	input  wire logic         shift,
	input  wire logic [W-1:0] newData,
	input  wire logic [W-1:0] shiftData,
	output logic      [W-1:0] q
);

	// no reset: contents survive a reset like non-volatile storage
	always_ff @(posedge clk) begin
		if (clear) begin
			q <= '0;
		end else if (load) begin
			q <= newData;
		end else if (shift) begin
			q <= shiftData;
		end
	end

endmodule

// file: verilog/fault_history_log.sv
// fault reporting: status word, last stop cause and ten-entry fault history
`include "fault_history_log_defines.svh"

// Overview of operation
// - error sets bit 13; classes one to four change state field
// - stop cause reads zero unless error present
// - each new error outside a running erase stored with its status
// - follow-on errors ignored until error reset
// - at most ten entries, kept across reset
// - erase write 1; reads nonzero until done
// - pointer reset write 1 selects oldest entry
// - each number read advances the pointer, stopping past slot ten
// - empty slot reads error number zero
// - slot one oldest, slot ten newest
// - number read latches whole entry into buffer
// - entry number is read-only 16 bits
// - class codes zero to four select reaction
// - entry time is 32-bit operating seconds
// - extra info is read-only 16 bits
module fault_history_log #(
	parameter int DEPTH        = `HIST_DEPTH,
	parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
	input  wire logic                              clk,
	input  wire logic                              rst_b,
	input  wire fault_history_pkg::fault_event_type faultEvent,
	input  wire logic                              faultReset,
	input  wire logic [31:0]                       operatingSeconds,
	input  wire logic [15:0]                       driveStatusIn,
	input  wire fault_history_pkg::param_req_type   paramReq,
	output logic      [31:0]                       paramRdData,
	output logic                                   paramAck,
	output logic      [15:0]                       driveStatusWord,
	output logic      [15:0]                       lastStopCause
);

	localparam int EW = $bits(fault_history_pkg::entry_type);
	localparam int PW = 4;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fault_history_pkg::erase_state_type eraseState_reg;
	fault_history_pkg::erase_state_type eraseState_next;
	fault_history_pkg::entry_type       hold_reg;
	fault_history_pkg::entry_type       hold_next;
	fault_history_pkg::entry_type       activeEntry_reg;
	fault_history_pkg::entry_type       newEntry;
	fault_history_pkg::entry_type       selEntry;
	logic [PW-1:0]                      eraseCnt_reg;
	logic [PW-1:0]                      eraseCnt_next;
	logic [PW-1:0]                      count_reg;
	logic [PW-1:0]                      count_next;
	logic [PW-1:0]                      ptr_reg;
	logic [PW-1:0]                      ptr_next;
	logic                               active_reg;
	logic                               active_next;
	logic [31:0]                        rdData_next;
	logic [15:0]                        status_next;
	logic [15:0]                        stopCause_next;
	logic [EW-1:0]                      slotQ [DEPTH];

	// ----------------------------------------------------------------
	// parameter access decode
	// ----------------------------------------------------------------
	logic selErase;
	logic selPtrReset;
	logic selNumber;
	logic selClass;
	logic selTime;
	logic selInfo;
	logic writeOne;
	logic eraseStart;
	logic ptrResetCmd;
	logic readNumber;
	logic eraseBusy;

	assign selErase    = paramReq.addr == `ADDR_ERASE_HISTORY;
	assign selPtrReset = paramReq.addr == `ADDR_READ_PTR_RESET;
	assign selNumber   = paramReq.addr == `ADDR_ENTRY_NUMBER;
	assign selClass    = paramReq.addr == `ADDR_ENTRY_CLASS;
	assign selTime     = paramReq.addr == `ADDR_ENTRY_TIME;
	assign selInfo     = paramReq.addr == `ADDR_ENTRY_EXTRA_INFO;
	assign writeOne    = paramReq.wr && (paramReq.wrData == `CMD_EXECUTE);
	assign eraseBusy   = eraseState_reg == fault_history_pkg::ERASE_BUSY;
	// a second erase while one runs is ignored
	assign eraseStart  = writeOne && selErase && !eraseBusy;
	assign ptrResetCmd = writeOne && selPtrReset;
	assign readNumber  = paramReq.rd && selNumber;

	// ----------------------------------------------------------------
	// error capture
	// ----------------------------------------------------------------
	logic logNew;
	logic histFull;

	// only the first error is logged until the fault is reset
	assign logNew   = faultEvent.valid && !active_reg && !eraseBusy;
	assign histFull = count_reg == PW'(DEPTH);

	assign newEntry.number = faultEvent.number;
	assign newEntry.cls    = faultEvent.cls;
	assign newEntry.info   = faultEvent.info;
	// operating-seconds counter is clipped to its documented range
	assign newEntry.time_s = (operatingSeconds > `TIME_MAX) ? `TIME_MAX : operatingSeconds;

	// ----------------------------------------------------------------
	// history memory
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_slot
			logic          slotLoad;
			logic          slotShift;
			logic [EW-1:0] shiftIn;

			// append at the first free slot, or at the newest slot when full
			assign slotLoad  = logNew && (histFull ? (gi == DEPTH - 1)
				: (count_reg == PW'(gi)));
			// full history moves every entry one slot towards the oldest
			assign slotShift = logNew && histFull;
			if (gi < DEPTH - 1) begin : g_mid
				assign shiftIn = slotQ[gi + 1];
			end else begin : g_top
				assign shiftIn = '0;
			end

			history_slot #(
				.W(EW)
			) u_slot (
				.clk      (clk),
				.clear    (eraseStart),
				.load     (slotLoad),
				.shift    (slotShift),
				.newData  (newEntry),
				.shiftData(shiftIn),
				.q        (slotQ[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// entry count
	// ----------------------------------------------------------------
	always_comb begin
		count_next = count_reg;
		if (eraseStart) begin
			count_next = '0;
		end else if (logNew && !histFull) begin
			count_next = count_reg + PW'(1);
		end
	end

	// ----------------------------------------------------------------
	// read pointer
	// ----------------------------------------------------------------
	logic ptrValid;

	assign ptrValid = ptr_reg < count_reg;
	// slot past the last stored entry reads as all zero
	assign selEntry = ptrValid ? fault_history_pkg::entry_type'(slotQ[ptr_reg]) : '0;

	always_comb begin
		ptr_next = ptr_reg;
		if (ptrResetCmd || eraseStart) begin
			ptr_next = '0;
		end else if (readNumber && (ptr_reg < PW'(DEPTH))) begin
			ptr_next = ptr_reg + PW'(1);
		end
	end

	// ----------------------------------------------------------------
	// holding buffer
	// ----------------------------------------------------------------
	always_comb begin
		hold_next = hold_reg;
		if (readNumber) begin
			hold_next = selEntry;
		end
	end

	// ----------------------------------------------------------------
	// erase sequencer
	// ----------------------------------------------------------------
	always_comb begin
		eraseState_next = eraseState_reg;
		eraseCnt_next   = eraseCnt_reg;
		unique case (eraseState_reg)
			fault_history_pkg::ERASE_IDLE: begin
				if (eraseStart) begin
					eraseState_next = fault_history_pkg::ERASE_BUSY;
					eraseCnt_next   = PW'(ERASE_CYCLES - 1);
				end
			end
			fault_history_pkg::ERASE_BUSY: begin
				if (eraseCnt_reg == '0) begin
					eraseState_next = fault_history_pkg::ERASE_IDLE;
				end else begin
					eraseCnt_next = eraseCnt_reg - PW'(1);
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// active error and status word
	// ----------------------------------------------------------------
	function automatic logic [3:0] reaction_state(input logic [2:0] cls, input logic [3:0] cur);
		logic [3:0] st;
		st = cur;
		unique case (cls)
			`CLASS_QSTOP_7:      st = `STATE_QUICK_STOP;
			`CLASS_QSTOP_8_9:    st = `STATE_FAULT_REACTION;
			`CLASS_FATAL:        st = `STATE_FAULT;
			`CLASS_FATAL_LOCKED: st = `STATE_FAULT;
			default:             st = cur;
		endcase
		return st;
	endfunction

	// a new error in the reset cycle is logged only if no error is active
	assign active_next = logNew || (active_reg && !faultReset);

	fault_history_pkg::entry_type curEntry;

	assign curEntry = logNew ? newEntry : activeEntry_reg;

	always_comb begin
		status_next = driveStatusIn;
		status_next[`STATUS_ERR_BIT] = active_next;
		if (active_next) begin
			status_next[`STATUS_STATE_LSB +: `STATUS_STATE_W] =
				reaction_state(curEntry.cls, driveStatusIn[`STATUS_STATE_LSB +: `STATUS_STATE_W]);
		end
	end

	assign stopCause_next = active_next ? curEntry.number : 16'h0000;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		rdData_next = 32'h0000_0000;
		if (paramReq.rd) begin
			if (selErase) begin
				rdData_next = {31'h0000_0000, eraseBusy};
			end else if (selNumber) begin
				rdData_next = {16'h0000, selEntry.number};
			end else if (selClass) begin
				rdData_next = {29'h0000_0000, hold_reg.cls};
			end else if (selTime) begin
				rdData_next = hold_reg.time_s;
			end else if (selInfo) begin
				rdData_next = {16'h0000, hold_reg.info};
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// history contents and count are not reset: they model retained storage
	always_ff @(posedge clk) begin
		count_reg <= count_next;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eraseState_reg <= fault_history_pkg::ERASE_IDLE;
			eraseCnt_reg   <= '0;
			ptr_reg        <= '0;
		end else begin
			eraseState_reg <= eraseState_next;
			eraseCnt_reg   <= eraseCnt_next;
			ptr_reg        <= ptr_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_reg        <= '0;
			activeEntry_reg <= '0;
			active_reg      <= 1'b0;
		end else begin
			hold_reg        <= hold_next;
			activeEntry_reg <= curEntry;
			active_reg      <= active_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			paramRdData     <= 32'h0000_0000;
			paramAck        <= 1'b0;
			driveStatusWord <= 16'h0000;
			lastStopCause   <= 16'h0000;
		end else begin
			paramRdData     <= rdData_next;
			paramAck        <= paramReq.rd || paramReq.wr;
			driveStatusWord <= status_next;
			lastStopCause   <= stopCause_next;
		end
	end

endmodule

// file: testbench/fault_history_log_properties.sv
// port assertions of the fault history log
`include "fault_history_log_defines.svh"
module fault_history_log_properties #(
	parameter int DEPTH        = 10,
	parameter int ERASE_CYCLES = 10
) (
	input wire logic                               clk,
	input wire logic                               rst_b,
	input wire fault_history_pkg::fault_event_type faultEvent,
	input wire logic                               faultReset,
	input wire logic [31:0]                        operatingSeconds,
	input wire logic [15:0]                        driveStatusIn,
	input wire fault_history_pkg::param_req_type   paramReq,
	input wire logic [31:0]                        paramRdData,
	input wire logic                               paramAck,
	input wire logic [15:0]                        driveStatusWord,
	input wire logic [15:0]                        lastStopCause
);
	timeunit 1ns;
	timeprecision 1ns;

	wire active  = driveStatusWord[`STATUS_ERR_BIT];
	wire rdNum   = paramReq.rd && paramReq.addr == `ADDR_ENTRY_NUMBER;
	wire rdClass = paramReq.rd && paramReq.addr == `ADDR_ENTRY_CLASS;
	wire rdTime  = paramReq.rd && paramReq.addr == `ADDR_ENTRY_TIME;
	wire rdInfo  = paramReq.rd && paramReq.addr == `ADDR_ENTRY_EXTRA_INFO;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_causeZero; !active |-> lastStopCause == 16'h0; endproperty
	a_causeZero: assert property (p_causeZero) else $error("stop cause set without error");
	property p_riseCause;
		$rose(active) |-> $past(faultEvent.valid) && lastStopCause == $past(faultEvent.number);
	endproperty
	a_riseCause: assert property (p_riseCause) else $error("error flag without matching event");
	property p_causeHold; active && !faultReset |=> active && $stable(lastStopCause); endproperty
	a_causeHold: assert property (p_causeHold) else $error("follow-on error replaced cause");
	property p_clear; faultReset && !faultEvent.valid |=> !active; endproperty
	a_clear: assert property (p_clear) else $error("error flag not cleared");
	property p_classState;
		$rose(active) && $past(faultEvent.cls) == `CLASS_QSTOP_7 |-> driveStatusWord[3:0] == `STATE_QUICK_STOP;
	endproperty
	a_classState: assert property (p_classState) else $error("wrong reaction state");
	property p_classWidth; rdClass |=> paramAck && paramRdData[31:3] == 29'h0; endproperty
	a_classWidth: assert property (p_classWidth) else $error("class read out of range");
	property p_numWidth; rdNum |=> paramAck && paramRdData[31:16] == 16'h0; endproperty
	a_numWidth: assert property (p_numWidth) else $error("number read wider than 16 bits");
	property p_timeMax; rdTime |=> paramAck && paramRdData <= `TIME_MAX; endproperty
	a_timeMax: assert property (p_timeMax) else $error("time read above maximum");
	property p_infoWidth; rdInfo |=> paramAck && paramRdData[31:16] == 16'h0; endproperty
	a_infoWidth: assert property (p_infoWidth) else $error("info read wider than 16 bits");

	c_fault: cover property ($rose(active));
	c_readNum: cover property (rdNum ##1 paramAck);
	c_erase: cover property (paramReq.wr && paramReq.addr == `ADDR_ERASE_HISTORY);
endmodule

bind fault_history_log fault_history_log_properties #(.DEPTH(DEPTH), .ERASE_CYCLES(ERASE_CYCLES))
	fault_history_log_properties_i (.clk(clk), .rst_b(rst_b), .faultEvent(faultEvent),
	.faultReset(faultReset), .operatingSeconds(operatingSeconds), .driveStatusIn(driveStatusIn),
	.paramReq(paramReq), .paramRdData(paramRdData), .paramAck(paramAck),
	.driveStatusWord(driveStatusWord), .lastStopCause(lastStopCause));

// file: testbench/fieldbus_master_model.sv
// fieldbus master model on the parameter port
`include "fault_history_log_defines.svh"
module fieldbus_master_model (
	input  wire logic                       clk,
	output fault_history_pkg::param_req_type paramReq,
	input  wire logic [31:0]                paramRdData,
	input  wire logic                       paramAck
);
	timeunit 1ns;
	timeprecision 1ns;
	int lost = 0;
	initial paramReq = '0;

	task automatic access(input logic w, input logic [15:0] a, d, output logic [31:0] q);
		int n;
		@(posedge clk);
		#1;
		paramReq.rd = !w;
		paramReq.wr = w;
		paramReq.addr = a;
		paramReq.wrData = d;
		@(posedge clk);
		#1;
		paramReq.rd = 1'b0;
		paramReq.wr = 1'b0;
		for (n = 0; n < 4 && paramAck !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (paramAck !== 1'b1) lost++;
		q = paramRdData;
		// released lines show the inverse
		paramReq.addr = ~a;
		paramReq.wrData = ~d;
	endtask

	task automatic erase(output int busy);
		logic [31:0] q;
		int n;
		busy = 0;
		access(1'b1, `ADDR_ERASE_HISTORY, `CMD_EXECUTE, q);
		for (n = 0; n < 64; n++) begin
			access(1'b0, `ADDR_ERASE_HISTORY, 16'h0, q);
			if (q === 32'h0) break;
			busy++;
		end
		if (n == 64) lost++;
	endtask

	task automatic rewind();
		logic [31:0] q;
		access(1'b1, `ADDR_READ_PTR_RESET, `CMD_EXECUTE, q);
	endtask

	task automatic readEntry(output fault_history_pkg::entry_type e);
		logic [31:0] q;
		access(1'b0, `ADDR_ENTRY_NUMBER, 16'h0, q);
		e.number = q[15:0];
		access(1'b0, `ADDR_ENTRY_CLASS, 16'h0, q);
		e.cls = q[2:0];
		access(1'b0, `ADDR_ENTRY_TIME, 16'h0, q);
		e.time_s = q;
		access(1'b0, `ADDR_ENTRY_EXTRA_INFO, 16'h0, q);
		e.info = q[15:0];
	endtask
endmodule

// file: testbench/fault_history_log_tb.sv
// self-checking testbench of the fault history log
`include "fault_history_log_defines.svh"
module fault_history_log_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                               clk, rst_b, faultReset, paramAck;
	logic [31:0]                        operatingSeconds, paramRdData, q;
	logic [15:0]                        driveStatusIn, driveStatusWord, lastStopCause;
	fault_history_pkg::fault_event_type faultEvent;
	fault_history_pkg::param_req_type   paramReq;
	fault_history_pkg::entry_type       hist[$];
	int                                 failures = 0, samplesChecked = 0, seed = 93, busy, i;

	fault_history_log #(.ERASE_CYCLES(5)) fault_history_log_i (.clk(clk), .rst_b(rst_b),
		.faultEvent(faultEvent), .faultReset(faultReset), .operatingSeconds(operatingSeconds),
		.driveStatusIn(driveStatusIn), .paramReq(paramReq), .paramRdData(paramRdData),
		.paramAck(paramAck), .driveStatusWord(driveStatusWord), .lastStopCause(lastStopCause));
	fieldbus_master_model fieldbus_master_model_i (.clk(clk), .paramReq(paramReq),
		.paramRdData(paramRdData), .paramAck(paramAck));

	task automatic results();
		failures += fieldbus_master_model_i.lost;
		$display("comparisons %0d failures %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, got);
		samplesChecked++;
		if (exp !== got) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkEntry(input fault_history_pkg::entry_type exp, got);
		samplesChecked++;
		if (exp !== got) begin
			failures++;
			$display("MISMATCH entry expected %h seen %h", exp, got);
		end
	endtask

	// ----------------------------------------------------------------
	// error event, follow-on error, clear
	// ----------------------------------------------------------------
	task automatic raise(input logic [2:0] cls);
		fault_history_pkg::entry_type e;
		logic [3:0] st;
		@(posedge clk);
		#1;
		e.number = 16'($random(seed)) | 16'h0001;
		e.info = 16'($random(seed));
		e.cls = cls;
		operatingSeconds = $random(seed);
		e.time_s = (operatingSeconds > `TIME_MAX) ? `TIME_MAX : operatingSeconds;
		faultEvent = '{1'b1, e.number, cls, e.info};
		hist.push_back(e);
		if (hist.size() > `HIST_DEPTH) void'(hist.pop_front());
		@(posedge clk);
		#1;
		faultEvent.valid = 1'b0;
		st = cls == 3'h1 ? 4'h7 : cls == 3'h2 ? 4'h8 : cls == 3'h0 ? driveStatusIn[3:0] : 4'h9;
		chk("status", 32'({driveStatusIn[15:14], 1'b1, driveStatusIn[12:4], st}), 32'(driveStatusWord));
		chk("cause", 32'(e.number), 32'(lastStopCause));
		@(posedge clk);
		#1;
		faultEvent = '{1'b1, ~e.number, 3'h3, 16'h0};
		@(posedge clk);
		#1;
		faultEvent.valid = 1'b0;
		faultReset = 1'b1;
		chk("causeKept", 32'(e.number), 32'(lastStopCause));
		@(posedge clk);
		#1;
		faultReset = 1'b0;
		chk("causeClear", 32'h0, 32'(lastStopCause));
		chk("statusClear", 32'({driveStatusIn[15:14], 1'b0, driveStatusIn[12:0]}), 32'(driveStatusWord));
	endtask

	task automatic readCheck(input int n);
		fault_history_pkg::entry_type got;
		int k;
		fieldbus_master_model_i.rewind();
		for (k = 0; k < n; k++) begin
			fieldbus_master_model_i.readEntry(got);
			if (k >= hist.size()) chk("emptyNumber", 32'h0, 32'(got.number));
			else chkEntry(hist[k], got);
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		rst_b = 1'b0;
		faultReset = 1'b0;
		faultEvent = '0;
		operatingSeconds = 32'h0;
		driveStatusIn = 16'($random(seed));
		repeat (16) @(posedge clk);
		#1;
		rst_b = 1'b1;
		fieldbus_master_model_i.erase(busy);
		chk("eraseBusy", 32'h1, 32'(busy > 0));
		fieldbus_master_model_i.access(1'b0, 16'h3c0a, 16'h0, q);
		chk("unmapped", 32'h0, q);
		readCheck(1);
		for (i = 0; i < 3; i++) raise(3'(i));
		readCheck(4);
		for (i = 3; i < 12; i++) raise(3'(i % 5));
		readCheck(`HIST_DEPTH);
		// reset in mid-run: history must survive it
		@(posedge clk);
		#1;
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk("statusReset", 32'h0, 32'(driveStatusWord));
		readCheck(`HIST_DEPTH);
		// erase a filled history
		fieldbus_master_model_i.erase(busy);
		chk("eraseBusyFull", 32'h1, 32'(busy > 0));
		hist.delete();
		readCheck(2);
		results();
	end
endmodule
